// ---- logic/cfg_prog_tap.v ----
`timescale 1ns/100ps
`include "cfg_prog_defines.vh"
module cfg_prog_tap #(
   parameter [`ID_W-1:0] ID_VALUE = 32'h1234_5001 // Identity word, value arbitrary
) (
   input wire clk,
   input wire sys_rst,
   input wire tck,
   input wire tms,
   input wire tdi,
   output reg tdo_r,
   output reg tdo_oe_r,
   input wire [`BSR_W-1:0] bscan_in,
   output reg [`BSR_W-1:0] bscan_out_r,
   output wire outputs_hiz,
   output wire bscan_drive,
   output wire intest_mode,
   output wire normal_op_en,
   input wire [`REG_AW-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_r
);
   // Test access port states
   localparam [3:0] ST_RESET = 4'h0;
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_SEL_DR = 4'h2;
   localparam [3:0] ST_CAP_DR = 4'h3;
   localparam [3:0] ST_SH_DR = 4'h4;
   localparam [3:0] ST_EX1_DR = 4'h5;
   localparam [3:0] ST_PA_DR = 4'h6;
   localparam [3:0] ST_EX2_DR = 4'h7;
   localparam [3:0] ST_UP_DR = 4'h8;
   localparam [3:0] ST_SEL_IR = 4'h9;
   localparam [3:0] ST_CAP_IR = 4'ha;
   localparam [3:0] ST_SH_IR = 4'hb;
   localparam [3:0] ST_EX1_IR = 4'hc;
   localparam [3:0] ST_PA_IR = 4'hd;
   localparam [3:0] ST_EX2_IR = 4'he;
   localparam [3:0] ST_UP_IR = 4'hf;

   wire [2:0] pin_lvl; // Filtered tck, tms, tdi
   wire [2:0] pin_raw; // Raw pins in one bus
   reg tck_d_r; // Previous filtered tck
   reg [3:0] tap_r; // TAP state
   reg [3:0] tap_nxt; // Next TAP state
   reg [`IR_W-1:0] ir_r; // Active instruction
   reg [`IR_W-1:0] ir_sr; // Instruction shift register
   reg [`ADDR_W-1:0] addr_r; // Row pointer
   reg [`COL_W_WIDE-1:0] col_sr; // Column data register
   reg [`TAG_W-1:0] tag_sr; // Tag shift register
   reg [`ID_W-1:0] id_sr; // Identity shift register
   reg [`BSR_W-1:0] bsr_sr; // Boundary shift register
   reg bypass_r; // Bypass bit
   reg prog_mode_r; // Programming mode active
   reg charged_r; // Programming supply still charged
   reg [31:0] ctrl_r; // Software control word
   reg dr_lsb; // Serial output of chosen register
   wire [`COL_W_WIDE-1:0] col_rdata; // Array read data
   wire [`TAG_W-1:0] nv_tag; // Stored tag word
   wire lock_fuse; // Lock fuse state
   wire valid_flag; // Configuration valid flag
   wire tck_rise; // Rising test clock
   wire tck_fall; // Falling test clock
   wire tms_l; // Filtered mode select
   wire tdi_l; // Filtered serial input
   wire wide; // Column register is 61 bits
   wire fire; // Instruction executes this edge
   wire [`IR_W-1:0] exec_ir; // Instruction being executed
   wire allowed; // Programming mode present, or the instruction does not need it
   wire [2:0] dr_sel; // Data register in use
   wire do_wipe;
   wire do_write;
   wire do_tag;
   wire do_lock;
   wire do_read;
   wire do_adv;

   // Data register chosen by an instruction
   function [2:0] dr_of;
      input [`IR_W-1:0] op;
      begin
         if (op[`IR_W-1]) begin
            dr_of = `DR_BYPASS;
         end else begin
            case (op)
               `OP_ROW_PTR_LOAD: dr_of = `DR_ADDR;
               `OP_COL_WORD_SHIFT: dr_of = `DR_COL;
               `OP_IDCODE: dr_of = `DR_ID;
               `OP_USERCODE: dr_of = `DR_TAG;
               `OP_EXTEST, `OP_SAMPLE, `OP_INTEST: dr_of = `DR_BSR;
               default: dr_of = `DR_BYPASS;
            endcase
         end
      end
   endfunction

   // Whether an instruction needs programming mode
   function needs_prog;
      input [`IR_W-1:0] op;
      begin
         case (op)
            `OP_WIPE, `OP_COL_WRITE, `OP_WRITE_ADV, `OP_LOCK_SET,
            `OP_COL_READBACK, `OP_READBACK_ADV, `OP_TAG_STORE: needs_prog = 1'b1;
            default: needs_prog = 1'b0;
         endcase
      end
   endfunction

   assign pin_raw = {tdi, tms, tck};

   // Synchronise the three test pins
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pin
         pin_filter u_filt (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin(pin_raw[g]),
            .level_r(pin_lvl[g])
         );
      end
   endgenerate

   assign tck_rise = pin_lvl[0] & ~tck_d_r;
   assign tck_fall = ~pin_lvl[0] & tck_d_r;
   assign tms_l = pin_lvl[1];
   assign tdi_l = pin_lvl[2];
   assign wide = ctrl_r[`CTRL_WIDE_BIT];

   // Execution point: leaving an update state into idle
   assign fire = tck_rise & ~tms_l & ((tap_r == ST_UP_IR) | (tap_r == ST_UP_DR));
   assign exec_ir = (tap_r == ST_UP_IR) ? ir_sr : ir_r;
   assign allowed = prog_mode_r | ~needs_prog(exec_ir);
   assign dr_sel = dr_of(ir_r);
   assign do_wipe = fire & prog_mode_r & (exec_ir == `OP_WIPE);
   assign do_write = fire & prog_mode_r & ((exec_ir == `OP_COL_WRITE) | (exec_ir == `OP_WRITE_ADV));
   assign do_tag = fire & prog_mode_r & (exec_ir == `OP_TAG_STORE);
   assign do_lock = fire & prog_mode_r & (exec_ir == `OP_LOCK_SET);
   assign do_read = fire & allowed & ((exec_ir == `OP_COL_READBACK) | (exec_ir == `OP_READBACK_ADV));
   assign do_adv = fire & allowed & ((exec_ir == `OP_WRITE_ADV) | (exec_ir == `OP_READBACK_ADV));

   // Pin modes follow the active instruction; normal operation follows the valid flag outside programming mode
   assign outputs_hiz = (ir_r == `OP_HIGHZ);
   assign bscan_drive = (ir_r == `OP_CLAMP) | (ir_r == `OP_IDLE_HOLD) | (ir_r == `OP_EXTEST);
   assign intest_mode = (ir_r == `OP_INTEST);
   assign normal_op_en = valid_flag & ~prog_mode_r;

   nv_store u_nv (
      .clk(clk),
      .sys_rst(sys_rst),
      .wipe(do_wipe),
      .col_wr(do_write),
      .col_addr(addr_r),
      .col_wdata(col_sr),
      .col_rdata(col_rdata),
      .tag_wr(do_tag),
      .tag_wdata(tag_sr),
      .tag_r(nv_tag),
      .fuse_set(do_lock),
      .lock_fuse_r(lock_fuse),
      .valid_set(fire & (exec_ir == `OP_READY_SET)),
      .valid_clr(fire & (exec_ir == `OP_READY_CLR)),
      .valid_flag_r(valid_flag)
   );

   // TAP next state from tms
   always @* begin
      case (tap_r)
         ST_RESET: tap_nxt = tms_l ? ST_RESET : ST_IDLE;
         ST_IDLE: tap_nxt = tms_l ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: tap_nxt = tms_l ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: tap_nxt = tms_l ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: tap_nxt = tms_l ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: tap_nxt = tms_l ? ST_UP_DR : ST_PA_DR;
         ST_PA_DR: tap_nxt = tms_l ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: tap_nxt = tms_l ? ST_UP_DR : ST_SH_DR;
         ST_UP_DR: tap_nxt = tms_l ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: tap_nxt = tms_l ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: tap_nxt = tms_l ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: tap_nxt = tms_l ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: tap_nxt = tms_l ? ST_UP_IR : ST_PA_IR;
         ST_PA_IR: tap_nxt = tms_l ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: tap_nxt = tms_l ? ST_UP_IR : ST_SH_IR;
         ST_UP_IR: tap_nxt = tms_l ? ST_SEL_DR : ST_IDLE;
         default: tap_nxt = ST_RESET;
      endcase
   end

   // Serial output bit of the selected data register
   always @* begin
      case (dr_sel)
         `DR_ADDR: dr_lsb = addr_r[0];
         `DR_COL: dr_lsb = col_sr[0];
         `DR_ID: dr_lsb = id_sr[0];
         `DR_TAG: dr_lsb = tag_sr[0];
         `DR_BSR: dr_lsb = bsr_sr[0];
         default: dr_lsb = bypass_r;
      endcase
   end

   // TAP state, instruction register and mode flags
   always @(posedge clk) begin
      if (sys_rst) begin
         tck_d_r <= 1'b0;
         tap_r <= ST_RESET;
         ir_r <= `OP_IDCODE;
         ir_sr <= `IR_CAPTURE;
         prog_mode_r <= 1'b0;
         charged_r <= 1'b0;
      end else begin
         tck_d_r <= pin_lvl[0];
         if (tck_rise) begin
            tap_r <= tap_nxt;
            if (tap_r == ST_RESET) begin
               ir_r <= `OP_IDCODE; // Identity selected after reset
            end
            if (tap_r == ST_CAP_IR) begin
               ir_sr <= `IR_CAPTURE;
            end else if (tap_r == ST_SH_IR) begin
               ir_sr <= {tdi_l, ir_sr[`IR_W-1:1]};
            end
            if (tap_r == ST_UP_IR) begin
               ir_r <= ir_sr;
            end
         end
         if (fire) begin
            if (exec_ir == `OP_PROG_MODE_ON) begin
               prog_mode_r <= 1'b1;
            end else if (exec_ir == `OP_PROG_MODE_OFF) begin
               prog_mode_r <= 1'b0;
            end
            if (do_wipe | do_write | do_tag | do_lock) begin
               charged_r <= 1'b1; // Supply raised by wipe, column write, tag store or lock set
            end else if (exec_ir == `OP_SUPPLY_BLEED) begin
               charged_r <= 1'b0;
            end
         end
      end
   end

   // Data registers: capture, shift, update and instruction effects
   always @(posedge clk) begin
      if (sys_rst) begin
         addr_r <= 10'h000;
         col_sr <= {`COL_W_WIDE{1'b0}};
         tag_sr <= 32'h0000_0000;
         id_sr <= ID_VALUE;
         bsr_sr <= 8'h00;
         bscan_out_r <= 8'h00;
         bypass_r <= 1'b0;
      end else if (tck_rise) begin
         if (tap_r == ST_CAP_DR) begin
            case (dr_sel)
               `DR_ID: id_sr <= ID_VALUE;
               `DR_BSR: bsr_sr <= bscan_in;
               `DR_BYPASS: bypass_r <= 1'b0;
               default: bypass_r <= 1'b0;
            endcase
         end else if (tap_r == ST_SH_DR) begin
            case (dr_sel)
               `DR_ADDR: addr_r <= {tdi_l, addr_r[`ADDR_W-1:1]};
               `DR_COL: begin
                  if (wide) begin
                     col_sr <= {tdi_l, col_sr[`COL_W_WIDE-1:1]};
                  end else begin
                     col_sr <= {{`COL_PAD{1'b0}}, tdi_l, col_sr[`COL_W_NARROW-1:1]};
                  end
               end
               `DR_ID: id_sr <= {tdi_l, id_sr[`ID_W-1:1]};
               `DR_TAG: tag_sr <= {tdi_l, tag_sr[`TAG_W-1:1]};
               `DR_BSR: bsr_sr <= {tdi_l, bsr_sr[`BSR_W-1:1]};
               default: bypass_r <= tdi_l;
            endcase
         end else if (tap_r == ST_UP_DR) begin
            if ((ir_r == `OP_SAMPLE) | (ir_r == `OP_EXTEST) | (ir_r == `OP_INTEST)) begin
               bscan_out_r <= bsr_sr;
            end
         end
         if ((tap_r == ST_UP_IR) & (ir_sr == `OP_USERCODE)) begin
            tag_sr <= nv_tag; // Tag stays readable under the lock
         end
         if (do_read) begin
            if (lock_fuse | charged_r) begin
               col_sr <= {`COL_W_WIDE{1'b0}}; // Readout refused
            end else if (wide) begin
               col_sr <= col_rdata;
            end else begin
               col_sr <= {{`COL_PAD{1'b0}}, col_rdata[`COL_W_NARROW-1:0]};
            end
         end
         if (do_adv) begin
            addr_r <= addr_r + 10'h001;
         end
      end
   end

   // Serial output changes on the falling test clock
   always @(posedge clk) begin
      if (sys_rst) begin
         tdo_r <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_r <= (tap_r == ST_SH_IR) | (tap_r == ST_SH_DR);
         tdo_r <= (tap_r == ST_SH_IR) ? ir_sr[0] : dr_lsb;
      end
   end

   // Software register port
   always @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r <= `CTRL_RESET;
         reg_rdata_r <= 32'h0000_0000;
      end else begin
         if (reg_wr & (reg_addr == `REG_CTRL)) begin
            ctrl_r <= reg_wdata;
         end
         if (reg_rd) begin
            case (reg_addr)
               `REG_CTRL: reg_rdata_r <= {31'h0000_0000, ctrl_r[`CTRL_WIDE_BIT]};
               `REG_STATUS: reg_rdata_r <= {28'h000_0000, charged_r, valid_flag, lock_fuse, prog_mode_r};
               `REG_ROWPTR: reg_rdata_r <= {22'h00_0000, addr_r};
               default: reg_rdata_r <= 32'h0000_0000; // Unmapped reads zero
            endcase
         end else begin
            reg_rdata_r <= 32'h0000_0000;
         end
      end
   end
endmodule // cfg_prog_tap

// ---- logic/cfg_prog_defines.vh ----
`ifndef CFG_PROG_DEFINES_VH
`define CFG_PROG_DEFINES_VH
// Instruction codes, all eight bits significant
`define IR_W 8
`define OP_EXTEST 8'h00
`define OP_ROW_PTR_LOAD 8'h01
`define OP_COL_WORD_SHIFT 8'h02
`define OP_WIPE 8'h03
`define OP_COL_WRITE 8'h07
`define OP_LOCK_SET 8'h09
`define OP_COL_READBACK 8'h0a
`define OP_SUPPLY_BLEED 8'h14
`define OP_PROG_MODE_ON 8'h15
`define OP_IDCODE 8'h16
`define OP_USERCODE 8'h17
`define OP_HIGHZ 8'h18
`define OP_TAG_STORE 8'h1a
`define OP_SAMPLE 8'h1c
`define OP_PROG_MODE_OFF 8'h1e
`define OP_CLAMP 8'h20
`define OP_READY_CLR 8'h24
`define OP_WRITE_ADV 8'h27
`define OP_READBACK_ADV 8'h2a
`define OP_INTEST 8'h2c
`define OP_READY_SET 8'h2f
`define OP_IDLE_HOLD 8'h30
`define IR_CAPTURE 8'h01
// Data register widths and array size
`define ADDR_W 10
`define COL_W_WIDE 61
`define COL_W_NARROW 43
`define COL_PAD 18
`define TAG_W 32
`define ID_W 32
`define BSR_W 8
`define ARRAY_DEPTH 1024
// Data register selectors
`define DR_BYPASS 3'h0
`define DR_ADDR 3'h1
`define DR_COL 3'h2
`define DR_ID 3'h3
`define DR_TAG 3'h4
`define DR_BSR 3'h5
// Software register port
`define REG_AW 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_ROWPTR 4'h8
`define CTRL_WIDE_BIT 0
`define CTRL_RESET 32'h0000_0000
`endif

// ---- logic/pin_filter.v ----
`timescale 1ns/100ps
`include "cfg_prog_defines.vh"
// Three-stage synchroniser; the output follows once stages two and three agree
module pin_filter (
   input wire clk,
   input wire sys_rst,
   input wire pin,
   output reg level_r
);
   reg s1_r; // First stage, read only by s2_r
   reg s2_r; // Second stage
   reg s3_r; // Third stage

   // Shift chain and agreement filter
   always @(posedge clk) begin
      if (sys_rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_r <= s3_r; // Stable value accepted
         end
      end
   end
endmodule // pin_filter

// ---- logic/nv_store.v ----
`timescale 1ns/100ps
`include "cfg_prog_defines.vh"
// Nonvolatile configuration store: columns, tag word, lock fuse, valid flag
module nv_store (
   input wire clk,
   input wire sys_rst,
   input wire wipe,
   input wire col_wr,
   input wire [`ADDR_W-1:0] col_addr,
   input wire [`COL_W_WIDE-1:0] col_wdata,
   output wire [`COL_W_WIDE-1:0] col_rdata,
   input wire tag_wr,
   input wire [`TAG_W-1:0] tag_wdata,
   output reg [`TAG_W-1:0] tag_r,
   input wire fuse_set,
   output reg lock_fuse_r,
   input wire valid_set,
   input wire valid_clr,
   output reg valid_flag_r
);
   reg [`COL_W_WIDE-1:0] cells [0:`ARRAY_DEPTH-1]; // Column array
   integer i;

   assign col_rdata = cells[col_addr];

   // Column array; a wipe clears every cell
   always @(posedge clk) begin
      if (wipe) begin
         for (i = 0; i < `ARRAY_DEPTH; i = i + 1) begin
            cells[i] <= {`COL_W_WIDE{1'b0}};
         end
      end else if (col_wr) begin
         cells[col_addr] <= col_wdata;
      end
   end

   // Tag word, lock fuse and valid flag
   always @(posedge clk) begin
      if (sys_rst) begin
         tag_r <= 32'h0000_0000;
         lock_fuse_r <= 1'b0;
         valid_flag_r <= 1'b0;
      end else begin
         if (wipe) begin
            tag_r <= 32'h0000_0000;
            lock_fuse_r <= 1'b0; // Only a wipe or sys_rst clears it
         end else begin
            if (tag_wr) begin
               tag_r <= tag_wdata;
            end
            if (fuse_set) begin
               lock_fuse_r <= 1'b1;
            end
         end
         if (valid_set) begin
            valid_flag_r <= 1'b1;
         end else if (valid_clr) begin
            valid_flag_r <= 1'b0;
         end
      end
   end
endmodule // nv_store

// ---- bench/jtag_host_model.sv ----
`timescale 1ns/100ps
// Boundary-scan controller: drives the test pins from the system clock
module jtag_host_model (
   input wire clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire tdo_r
);
   // Pins at rest: clock still, mode and data at pull-up level
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One test clock: four clocks low, four high; tdo taken before the fall
   task automatic step(input logic m, input logic d, output logic q);
      begin
         @(posedge clk);
         tms <= m;
         tdi <= d;
         repeat (3) @(posedge clk);
         tck <= 1'b1;
         repeat (4) @(posedge clk);
         q = tdo_r;
         tck <= 1'b0;
      end
   endtask
   // Five high mode bits reach test-logic-reset, then into idle
   task automatic reset_tap;
      logic q;
      begin
         repeat (5) step(1'b1, 1'b1, q);
         step(1'b0, 1'b1, q);
      end
   endtask
   // Scan n bits least significant first, ending in idle so the op runs
   task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
      logic q;
      begin
         dout = '0;
         step(1'b1, 1'b1, q);
         // Instruction path needs one more select
         if (ir) begin
            step(1'b1, 1'b1, q);
         end
         step(1'b0, 1'b1, q);
         step(1'b0, 1'b1, q);
         for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
         end
         // Update, then idle; data line back to pull-up
         step(1'b1, 1'b1, q);
         step(1'b0, 1'b1, q);
         // Let the filtered last rise and fall act before returning
         repeat (8) @(posedge clk);
      end
   endtask
endmodule // jtag_host_model

// ---- bench/cfg_prog_monitor.sv ----
`timescale 1ns/100ps
`include "cfg_prog_defines.vh"
// Port-level checks on the programming access port
module cfg_prog_monitor (
   input wire clk,
   input wire sys_rst,
   input wire tck,
   input wire tdo_r,
   input wire tdo_oe_r,
   input wire outputs_hiz,
   input wire bscan_drive,
   input wire intest_mode,
   input wire normal_op_en,
   input wire [`REG_AW-1:0] reg_addr,
   input wire reg_rd,
   input wire [31:0] reg_rdata_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Pin modes move only after a test clock rise
   hiz_tck_a: assert property ($changed(outputs_hiz) |-> $past(tck, 2) && $past(tck, 3))
      else $error("high-z mode changed without a test clock rise");
   drive_tck_a: assert property ($changed(bscan_drive) |-> $past(tck, 2) && $past(tck, 3))
      else $error("clamp mode changed without a test clock rise");
   intest_tck_a: assert property ($changed(intest_mode) |-> $past(tck, 2) && $past(tck, 3))
      else $error("internal test mode changed without a test clock rise");
   normal_tck_a: assert property ($changed(normal_op_en) |-> $past(tck, 2) && $past(tck, 3))
      else $error("normal operation changed without a test clock rise");
   // One instruction at a time selects a pin mode
   hiz_excl_a: assert property (outputs_hiz |-> !bscan_drive && !intest_mode)
      else $error("high-z overlaps another pin mode");
   drive_excl_a: assert property (bscan_drive |-> !intest_mode)
      else $error("clamp overlaps internal test");
   // Status flags agree with the normal operation output
   status_normal_a: assert property (reg_rd && reg_addr == `REG_STATUS |=>
      (reg_rdata_r[2] && !reg_rdata_r[0]) == $past(normal_op_en))
      else $error("status flags disagree with normal operation");
   // Serial output only moves after a test clock fall
   tdo_fall_a: assert property ($changed(tdo_r) |-> !$past(tck, 2) && !$past(tck, 3))
      else $error("serial output moved while test clock high");
   oe_fall_a: assert property ($changed(tdo_oe_r) |-> !$past(tck, 2) && !$past(tck, 3))
      else $error("output enable moved while test clock high");
   // Read data only in the cycle after a read
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
      else $error("read data outside its cycle");
endmodule // cfg_prog_monitor
bind cfg_prog_tap cfg_prog_monitor u_cfg_prog_monitor (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tdo_r(tdo_r),
   .tdo_oe_r(tdo_oe_r), .outputs_hiz(outputs_hiz), .bscan_drive(bscan_drive), .intest_mode(intest_mode),
   .normal_op_en(normal_op_en), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));

// ---- bench/tb_cfg_prog_tap.sv ----
`timescale 1ns/100ps
`include "cfg_prog_defines.vh"
// Programs, reads back, locks and wipes the array through the test port
module tb_cfg_prog_tap;
   localparam [31:0] ID_EXP = 32'h1234_5001; // Identity word, value arbitrary
   localparam [63:0] D1 = 64'h0000_0512_3456_789a; // First column word
   localparam [63:0] D2 = 64'h0000_02ed_cba9_8765; // Second column word
   localparam [63:0] TAG = 64'h0000_0000_c0de_7a95; // User tag word
   logic clk, sys_rst, reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, rd;
   logic [63:0] got;
   wire tck, tms, tdi, tdo_r, tdo_oe_r, outputs_hiz, bscan_drive, intest_mode, normal_op_en;
   wire [7:0] bscan_out_r;
   wire [31:0] reg_rdata_r;
   int n_mismatch, checks;
   logic [7:0] ops [7] = '{`OP_HIGHZ, `OP_CLAMP, `OP_IDLE_HOLD, `OP_EXTEST, `OP_INTEST, 8'h98, `OP_IDCODE};
   logic [2:0] modes [7] = '{3'h4, 3'h2, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0}; // Hi-z, drive, intest
   cfg_prog_tap #(.ID_VALUE(ID_EXP)) u_cfg_prog_tap (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo_r(tdo_r), .tdo_oe_r(tdo_oe_r), .bscan_in(8'h5a), .bscan_out_r(bscan_out_r),
      .outputs_hiz(outputs_hiz), .bscan_drive(bscan_drive), .intest_mode(intest_mode),
      .normal_op_en(normal_op_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
   jtag_host_model u_jtag_host_model (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_r(tdo_r));
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Compare and count
   task automatic expect_eq(input logic [63:0] g, input logic [63:0] e, input string what);
      begin
         checks++;
         if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
         end
      end
   endtask
   // Verdict and end of run
   task automatic wrap_up;
      begin
         $display("checks %0d n_mismatch %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // Register port accesses
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task automatic reg_read(input logic [3:0] a);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         @(negedge clk);
         rd = reg_rdata_r;
      end
   endtask
   // Status nibble: supply, valid, lock, mode
   task automatic status(input logic [3:0] e);
      begin
         reg_read(`REG_STATUS);
         expect_eq(rd[3:0], e, "status");
      end
   endtask
   task automatic rowptr(input logic [9:0] e);
      begin
         reg_read(`REG_ROWPTR);
         expect_eq(rd[9:0], e, "row pointer");
      end
   endtask
   // Scan helpers
   task automatic ir(input logic [7:0] op);
      u_jtag_host_model.scan(1'b1, {56'h0, op}, 8, got);
   endtask
   task automatic dr(input logic [63:0] d, input int n);
      u_jtag_host_model.scan(1'b0, d, n, got);
   endtask
   task automatic col_out(input logic [63:0] e);
      begin
         ir(`OP_COL_WORD_SHIFT);
         dr(64'h0, 43);
         expect_eq(got, e, "column readback");
      end
   endtask
   // Bound on the whole run
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      $display("mismatch at %0t: run timed out", $time);
      wrap_up();
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      u_jtag_host_model.reset_tap();
      dr(64'h0, 32);
      expect_eq(got, ID_EXP, "identity");
      ir(8'hff);
      expect_eq(got, 64'h01, "ir capture");
      dr(64'h3, 2);
      expect_eq(got, 64'h2, "bypass");
      $display("test identity done");
      // Array ops outside programming mode are refused
      ir(`OP_ROW_PTR_LOAD);
      dr(64'h5, 10);
      ir(`OP_WRITE_ADV);
      ir(`OP_LOCK_SET);
      rowptr(10'h5);
      status(4'h0);
      $display("test refused done");
      // Program two columns, then read them back
      ir(`OP_PROG_MODE_ON);
      status(4'h1);
      ir(`OP_WIPE);
      status(4'h9);
      ir(`OP_ROW_PTR_LOAD);
      dr(64'h5, 10);
      rowptr(10'h5);
      ir(`OP_COL_WORD_SHIFT);
      dr(D1, 43);
      ir(`OP_WRITE_ADV);
      rowptr(10'h6);
      ir(`OP_COL_WORD_SHIFT);
      dr(D2, 43);
      ir(`OP_COL_WRITE);
      ir(`OP_SUPPLY_BLEED);
      status(4'h1);
      ir(`OP_ROW_PTR_LOAD);
      dr(64'h5, 10);
      ir(`OP_READBACK_ADV);
      rowptr(10'h6);
      col_out(D1);
      ir(`OP_COL_READBACK);
      col_out(D2);
      $display("test program done");
      // User tag store and reload
      ir(`OP_USERCODE);
      dr(TAG, 32);
      ir(`OP_TAG_STORE);
      ir(`OP_SUPPLY_BLEED);
      ir(`OP_USERCODE);
      dr(64'h0, 32);
      expect_eq(got, TAG, "tag");
      $display("test tag done");
      // Lock blocks readout except identity and tag
      ir(`OP_LOCK_SET);
      status(4'hb);
      ir(`OP_SUPPLY_BLEED);
      ir(`OP_COL_READBACK);
      col_out(64'h0);
      ir(`OP_USERCODE);
      dr(64'h0, 32);
      expect_eq(got, TAG, "locked tag");
      ir(`OP_IDCODE);
      dr(64'h0, 32);
      expect_eq(got, ID_EXP, "locked identity");
      ir(`OP_PROG_MODE_OFF);
      ir(`OP_WIPE);
      status(4'h2);
      ir(`OP_PROG_MODE_ON);
      ir(`OP_WIPE);
      status(4'h9);
      ir(`OP_SUPPLY_BLEED);
      ir(`OP_USERCODE);
      dr(64'h0, 32);
      expect_eq(got, 64'h0, "wiped tag");
      $display("test lock done");
      // Valid flag and normal operation
      ir(`OP_READY_SET);
      status(4'h5);
      ir(`OP_PROG_MODE_OFF);
      expect_eq(normal_op_en, 1'b1, "normal on");
      ir(`OP_READY_CLR);
      status(4'h0);
      expect_eq(normal_op_en, 1'b0, "normal off");
      $display("test valid flag done");
      // Pin control instructions
      for (int i = 0; i < 7; i++) begin
         ir(ops[i]);
         expect_eq({outputs_hiz, bscan_drive, intest_mode}, modes[i], "pin mode");
      end
      // Boundary capture of the pins and update latch
      ir(`OP_SAMPLE);
      dr(64'h3c, 8);
      expect_eq(got, 64'h5a, "boundary capture");
      expect_eq(bscan_out_r, 8'h3c, "boundary update");
      $display("test pin modes done");
      // Register port: control, ignored write, unmapped read
      reg_write(`REG_CTRL, 32'h0);
      reg_write(`REG_STATUS, 32'hf);
      reg_read(`REG_CTRL);
      expect_eq(rd, 32'h0, "control");
      status(4'h0);
      reg_read(4'hc);
      expect_eq(rd, 32'h0, "unmapped");
      // Wide column register: 61 bits shift through
      reg_write(`REG_CTRL, 32'h1);
      reg_read(`REG_CTRL);
      expect_eq(rd, 32'h1, "control wide");
      ir(`OP_COL_WORD_SHIFT);
      dr(64'h1000_0512_3456_789a, 61);
      dr(64'h0, 61);
      expect_eq(got, 64'h1000_0512_3456_789a, "wide column");
      $display("test registers done");
      wrap_up();
   end
endmodule // tb_cfg_prog_tap
